// ---- src/hcs_clk_sel.sv ----
// High-speed clock source select, rate enables and AXI4-Lite registers
// Overview of operation
// - Wake-up timers get the selected low-speed tick; everything else runs from the high-speed tick or its divisions.
// - The radio gets the selected high-speed tick undivided and the peripherals a half-rate tick.
// - The processor rate is the high-speed tick divided by 1, 2, 4, 8, 16 or 32.
// - After reset and after every sleep the high-speed source restarts on the RC oscillator.
// - After wake-up the block switches to the crystal automatically, on software request, or never until sleep.
// - The switch to the crystal waits for the crystal amplitude-good flag.
// - Processor and peripheral rates are derived from the RC tick the same way as from the crystal.
// - The RC trim value is held across rate changes, sleep and oscillator disable.
// - The low-speed source starts on the RC oscillator and a different choice is locked until reset.
`timescale 1ns/1ps
`default_nettype none
module hcs_clk_sel
    import hcs_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    // Oscillator ticks, one cycle each, and crystal status
    input wire logic RC_TICK,
    input wire logic XTAL_TICK,
    input wire logic XTAL_GOOD,
    input wire logic LF_RC_TICK,
    input wire logic LF_EXT_TICK,
    input wire logic LF_XTAL_TICK,
    input wire logic SLEEP,
    // Oscillator controls
    output logic RC_EN,
    output logic XTAL_EN,
    output logic [7:0] RC_TRIM,
    // Derived enables
    output logic RADIO_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic CPU_CLK_EN,
    output logic WAKE_TMR_EN,
    output logic ON_XTAL,
    // AXI4-Lite slave
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [3:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        hcs_state_t state;
        hcs_mode_t mode;
        logic sw_req;
        logic [2:0] cpu_div;
        logic [7:0] trim;
        hcs_lf_t lf_sel;
        logic aw_got;
        logic [3:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic radio_en;
        logic wake_en;
    } hcs_st_t;

    hcs_st_t s_q;
    hcs_st_t s_d;
    hcs_div_if dvif ();

    hcs_hsdiv #(
        .NUM_DIV(HCS_NUM_DIV)
    ) u_div (
        .clk(CLK),
        .rst(RST),
        .dv(dvif.div)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Build-time checks

    // Every rate the divider offers must be nameable by the three-bit select field
    if (HCS_NUM_DIV < 1 || HCS_NUM_DIV > (1 << HCS_DIV_W)) begin : g_bad_div
        $error("Divider count does not fit its select field");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte lane merge for a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    function automatic logic [31:0] ctrl_word(input hcs_st_t s);
        logic [31:0] r;
        r = '0;
        r[HCS_CTRL_MODE_LSB +: 2] = s.mode;
        r[HCS_CTRL_SWREQ_BIT] = s.sw_req;
        r[HCS_CTRL_DIV_LSB +: 3] = s.cpu_div;
        ctrl_word = r;
    endfunction : ctrl_word

    logic hs_src_tick;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic [31:0] wv;
    logic [31:0] status;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes and source tick

    assign AWREADY = !s_q.aw_got && !s_q.bvalid;
    assign WREADY = !s_q.w_got && !s_q.bvalid;
    assign ARREADY = !s_q.rvalid;
    assign aw_hs = AWVALID && AWREADY;
    assign w_hs = WVALID && WREADY;
    assign ar_hs = ARVALID && ARREADY;
    assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;

    // Only the tick of the active source passes; none while asleep
    always_comb begin
        hs_src_tick = 1'b0;
        if (!SLEEP) begin
            case (s_q.state)
                HCS_S_XTAL: hs_src_tick = XTAL_TICK;
                default: hs_src_tick = RC_TICK;
            endcase
        end
    end

    always_comb begin
        status = '0;
        status[HCS_ST_XTAL_BIT] = (s_q.state == HCS_S_XTAL);
        status[HCS_ST_GOOD_BIT] = XTAL_GOOD;
        status[HCS_ST_REQ_BIT] = s_q.sw_req;
        status[HCS_ST_DIV_LSB +: 3] = dvif.div_act;
        status[HCS_ST_LF_LSB +: 2] = s_q.lf_sel;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        wv = '0;
        s_d.radio_en = hs_src_tick;
        // Low-speed tick from the locked source
        case (s_q.lf_sel)
            HCS_LF_EXT: s_d.wake_en = LF_EXT_TICK;
            HCS_LF_XTAL: s_d.wake_en = LF_XTAL_TICK;
            default: s_d.wake_en = LF_RC_TICK;
        endcase

        // Source selection
        if (SLEEP) begin
            s_d.state = HCS_S_RC;
            s_d.sw_req = 1'b0;
        end else begin
            case (s_q.state)
                HCS_S_RC: begin
                    if (s_q.mode == HCS_MODE_AUTO || (s_q.mode == HCS_MODE_SW && s_q.sw_req)) begin
                        s_d.state = HCS_S_WAIT;
                    end
                end
                HCS_S_WAIT: begin
                    // Hand over right after an RC tick so the gap never shrinks
                    if (XTAL_GOOD && RC_TICK) begin
                        s_d.state = HCS_S_XTAL;
                        s_d.sw_req = 1'b0;
                    end
                end
                HCS_S_XTAL: s_d.state = HCS_S_XTAL;
                default: s_d.state = HCS_S_RC;
            endcase
        end

        // Write channel
        if (aw_hs) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = AWADDR;
        end
        if (w_hs) begin
            s_d.w_got = 1'b1;
            s_d.wdata = WDATA;
            s_d.wstrb = WSTRB;
        end
        if (do_write) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = HCS_RESP_OKAY;
            case (s_q.awaddr)
                HCS_OFF_CTRL: begin
                    wv = merge(ctrl_word(s_q), s_q.wdata, s_q.wstrb);
                    if (wv[HCS_CTRL_MODE_LSB +: 2] <= 2'(HCS_MODE_STAY)) begin
                        s_d.mode = hcs_mode_t'(wv[HCS_CTRL_MODE_LSB +: 2]);
                    end
                    // A request written while asleep is dropped with the sleep
                    if (s_q.wstrb[0] && s_q.wdata[HCS_CTRL_SWREQ_BIT] && !SLEEP) begin
                        s_d.sw_req = 1'b1;
                    end
                    s_d.cpu_div = wv[HCS_CTRL_DIV_LSB +: 3];
                end
                HCS_OFF_RCCAL: begin
                    // Only lane 0 carries trim bits; the upper lanes are ignored
                    wv = merge(32'(s_q.trim), s_q.wdata, s_q.wstrb);
                    s_d.trim = wv[7:0];
                end
                HCS_OFF_LFSEL: begin
                    // Once off the RC source the choice is frozen until reset
                    if (s_q.lf_sel == HCS_LF_RC && s_q.wstrb[0] && s_q.wdata[1:0] <= 2'(HCS_LF_XTAL)) begin
                        s_d.lf_sel = hcs_lf_t'(s_q.wdata[1:0]);
                    end
                end
                HCS_OFF_STATUS: s_d.bresp = HCS_RESP_SLVERR;
                default: s_d.bresp = HCS_RESP_SLVERR;
            endcase
        end
        if (s_q.bvalid && BREADY) begin
            s_d.bvalid = 1'b0;
        end

        // Read channel
        if (ar_hs) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = HCS_RESP_OKAY;
            case (ARADDR)
                HCS_OFF_CTRL: s_d.rdata = ctrl_word(s_q);
                HCS_OFF_RCCAL: s_d.rdata = 32'(s_q.trim);
                HCS_OFF_LFSEL: s_d.rdata = 32'(s_q.lf_sel);
                HCS_OFF_STATUS: s_d.rdata = status;
                default: begin
                    s_d.rdata = '0;
                    s_d.rresp = HCS_RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid && RREADY) begin
            s_d.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
            s_q.state <= HCS_S_RC;
            s_q.mode <= hcs_mode_t'(HCS_MODE_RST);
            s_q.cpu_div <= HCS_DIV_RST;
            s_q.trim <= HCS_TRIM_RST;
            s_q.lf_sel <= HCS_LF_RC;
            s_q.bresp <= HCS_RESP_OKAY;
            s_q.rresp <= HCS_RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign dvif.hs_tick = hs_src_tick;
    assign dvif.div_sel = s_q.cpu_div;
    // The RC oscillator runs until the crystal has taken over; trim is kept while it is off
    assign RC_EN = !SLEEP && (s_q.state != HCS_S_XTAL);
    assign XTAL_EN = !SLEEP && (s_q.state != HCS_S_RC);
    assign RC_TRIM = s_q.trim;
    assign RADIO_CLK_EN = s_q.radio_en;
    assign PERIPH_CLK_EN = dvif.periph_en;
    assign CPU_CLK_EN = dvif.cpu_en;
    assign WAKE_TMR_EN = s_q.wake_en;
    // Software checks this before using the radio or UARTs
    assign ON_XTAL = (s_q.state == HCS_S_XTAL);
    assign BVALID = s_q.bvalid;
    assign BRESP = s_q.bresp;
    assign RVALID = s_q.rvalid;
    assign RDATA = s_q.rdata;
    assign RRESP = s_q.rresp;
endmodule : hcs_clk_sel
`default_nettype wire

// ---- src/hcs_div_if.sv ----
// Link between the source selector and the rate divider
`timescale 1ns/1ps
`default_nettype none
interface hcs_div_if;
    logic hs_tick;
    logic [2:0] div_sel;
    logic periph_en;
    logic cpu_en;
    logic [2:0] div_act;
    modport sel (output hs_tick, output div_sel, input periph_en, input cpu_en, input div_act);
    modport div (input hs_tick, input div_sel, output periph_en, output cpu_en, output div_act);
endinterface : hcs_div_if
`default_nettype wire

// ---- src/hcs_hsdiv.sv ----
// Peripheral and processor clock enable divider
`timescale 1ns/1ps
`default_nettype none
module hcs_hsdiv
    import hcs_pkg::*;
#(
    parameter int NUM_DIV = HCS_NUM_DIV
) (
    input wire logic clk,
    input wire logic rst,
    hcs_div_if.div dv
);
    localparam int CW = HCS_CNT_W;

    if (NUM_DIV < 1 || NUM_DIV > CW + 1) begin : g_bad_num_div
        $error("NUM_DIV out of range");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [2:0] sel;
        logic periph_en;
        logic cpu_en;
    } hcs_div_st_t;

    hcs_div_st_t s_q;
    hcs_div_st_t s_d;

    function automatic logic [CW-1:0] div_mask(input logic [2:0] sel);
        div_mask = CW'((32'h1 << sel) - 32'h1);
    endfunction : div_mask

    always_comb begin
        s_d = s_q;
        s_d.periph_en = 1'b0;
        s_d.cpu_en = 1'b0;
        if (dv.hs_tick) begin
            s_d.cnt = s_q.cnt + CW'(1);
            s_d.periph_en = s_q.cnt[0];
            s_d.cpu_en = (s_q.cnt & div_mask(s_q.sel)) == div_mask(s_q.sel);
            // New rate only at the slowest period boundary, so no short pulse
            if (&s_q.cnt) begin
                s_d.sel = (int'(dv.div_sel) < NUM_DIV) ? dv.div_sel : s_q.sel;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dv.periph_en = s_q.periph_en;
    assign dv.cpu_en = s_q.cpu_en;
    assign dv.div_act = s_q.sel;
endmodule : hcs_hsdiv
`default_nettype wire

// ---- src/hcs_pkg.sv ----
// Shared constants and types of the high-speed clock select block
package hcs_pkg;
    // Register byte offsets
    localparam logic [3:0] HCS_OFF_CTRL = 4'h0;
    localparam logic [3:0] HCS_OFF_RCCAL = 4'h4;
    localparam logic [3:0] HCS_OFF_LFSEL = 4'h8;
    localparam logic [3:0] HCS_OFF_STATUS = 4'hc;
    // CTRL field positions
    localparam int HCS_CTRL_MODE_LSB = 0;
    localparam int HCS_CTRL_SWREQ_BIT = 2;
    localparam int HCS_CTRL_DIV_LSB = 4;
    // STATUS field positions
    localparam int HCS_ST_XTAL_BIT = 0;
    localparam int HCS_ST_GOOD_BIT = 1;
    localparam int HCS_ST_REQ_BIT = 2;
    localparam int HCS_ST_DIV_LSB = 4;
    localparam int HCS_ST_LF_LSB = 8;
    // Reset values
    localparam logic [1:0] HCS_MODE_RST = 2'h0;
    localparam logic [2:0] HCS_DIV_RST = 3'h0;
    localparam logic [7:0] HCS_TRIM_RST = 8'h80;
    // Divider: six processor rates, 32 MHz down to 1 MHz
    localparam int HCS_DIV_W = 3;
    localparam int HCS_NUM_DIV = 6;
    localparam int HCS_CNT_W = 5;
    // AXI responses
    localparam logic [1:0] HCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] HCS_RESP_SLVERR = 2'h2;
    // Switch-over behaviour after wake-up
    typedef enum logic [1:0] {
        HCS_MODE_AUTO = 2'h0,
        HCS_MODE_SW = 2'h1,
        HCS_MODE_STAY = 2'h2
    } hcs_mode_t;
    // Low-speed source
    typedef enum logic [1:0] {
        HCS_LF_RC = 2'h0,
        HCS_LF_EXT = 2'h1,
        HCS_LF_XTAL = 2'h2
    } hcs_lf_t;
    // High-speed source state, one-hot
    typedef enum logic [2:0] {
        HCS_S_RC = 3'b001,
        HCS_S_WAIT = 3'b010,
        HCS_S_XTAL = 3'b100
    } hcs_state_t;
endpackage : hcs_pkg

// ---- testbench/hcs_clk_sel_asserts.sv ----
// Port-level checks of the high-speed clock select block
`timescale 1ns/1ps
`default_nettype none
module hcs_clk_sel_asserts (
    input wire logic CLK,
    input wire logic RST,
    input wire logic RC_TICK,
    input wire logic XTAL_TICK,
    input wire logic XTAL_GOOD,
    input wire logic LF_RC_TICK,
    input wire logic LF_EXT_TICK,
    input wire logic LF_XTAL_TICK,
    input wire logic SLEEP,
    input wire logic RC_EN,
    input wire logic XTAL_EN,
    input wire logic RADIO_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic CPU_CLK_EN,
    input wire logic WAKE_TMR_EN,
    input wire logic ON_XTAL,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic RVALID,
    input wire logic RREADY
);
////////////////////////////////////////
// Radio pulses since the last peripheral pulse; parity is not trusted across sleep
logic [1:0] gap_q;
logic seen_q;
always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
        gap_q <= 2'h0;
        seen_q <= 1'b0;
    end else if (PERIPH_CLK_EN) begin
        gap_q <= 2'h0;
        seen_q <= !SLEEP;
    end else begin
        seen_q <= seen_q && !SLEEP;
        if (RADIO_CLK_EN && gap_q != 2'h3) gap_q <= gap_q + 2'h1;
    end
end
////////////////////////////////////////
default clocking cb @(posedge CLK); endclocking
default disable iff (RST);
a_rc_radio: assert property (!ON_XTAL && RC_TICK && !SLEEP |=> RADIO_CLK_EN) else $error("no radio pulse on rc");
a_xtal_radio: assert property (ON_XTAL && XTAL_TICK && !SLEEP |=> RADIO_CLK_EN) else $error("no radio pulse");
a_no_spur: assert property (!(RC_TICK || XTAL_TICK) |=> !RADIO_CLK_EN) else $error("radio pulse without tick");
a_periph_half: assert property (PERIPH_CLK_EN |-> RADIO_CLK_EN && (!seen_q || gap_q == 2'h1)) else $error("periph rate");
a_cpu_in_radio: assert property (CPU_CLK_EN |-> RADIO_CLK_EN) else $error("cpu pulse off grid");
a_sleep_gates: assert property (SLEEP |-> !RC_EN && !XTAL_EN ##1 !RADIO_CLK_EN) else $error("active in sleep");
a_wake_rc: assert property ($fell(SLEEP) |-> !ON_XTAL && RC_EN && !XTAL_EN) else $error("wake not on rc");
a_switch_good: assert property ($rose(ON_XTAL) |-> $past(XTAL_GOOD && RC_TICK && XTAL_EN)) else $error("early switch");
a_wake_tick: assert property (WAKE_TMR_EN |-> $past(LF_RC_TICK || LF_EXT_TICK || LF_XTAL_TICK)) else $error("wake tick");
a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
a_rd_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read data dropped");
c_switch: cover property ($rose(ON_XTAL));
c_wake: cover property ($fell(SLEEP));
c_cpu_slow: cover property (RADIO_CLK_EN && !CPU_CLK_EN);
endmodule : hcs_clk_sel_asserts
bind hcs_clk_sel hcs_clk_sel_asserts u_chk (
    .CLK(CLK), .RST(RST), .RC_TICK(RC_TICK), .XTAL_TICK(XTAL_TICK), .XTAL_GOOD(XTAL_GOOD),
    .LF_RC_TICK(LF_RC_TICK), .LF_EXT_TICK(LF_EXT_TICK), .LF_XTAL_TICK(LF_XTAL_TICK), .SLEEP(SLEEP),
    .RC_EN(RC_EN), .XTAL_EN(XTAL_EN), .RADIO_CLK_EN(RADIO_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .CPU_CLK_EN(CPU_CLK_EN), .WAKE_TMR_EN(WAKE_TMR_EN), .ON_XTAL(ON_XTAL), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY));
`default_nettype wire

// ---- testbench/hcs_osc_model.sv ----
// Behavioural crystal, RC and low-speed oscillator sources
`timescale 1ns/1ps
`default_nettype none
module hcs_osc_model (
    input wire logic clk,
    input wire logic rc_en,
    input wire logic xtal_en,
    input wire logic [7:0] good_wait,
    output logic rc_tick,
    output logic xtal_tick,
    output logic xtal_good,
    output logic lf_rc,
    output logic lf_ext,
    output logic lf_xtal
);
logic [7:0] run_q = 8'h0;
logic [3:0] lf_q = 4'h0;
initial {rc_tick, xtal_tick, xtal_good, lf_rc, lf_ext, lf_xtal} = 6'h0;
////////////////////////////////////////
always @(posedge clk) begin
    // RC at half rate so the two sources can be told apart at the enables
    rc_tick <= rc_en && !rc_tick;
    xtal_tick <= xtal_en;
    // Good flag drops at once when disabled: no kinder than a real crystal
    run_q <= !xtal_en ? 8'h0 : (run_q == 8'hff ? run_q : run_q + 8'h1);
    xtal_good <= xtal_en && run_q >= good_wait;
    lf_q <= lf_q + 4'h1;
    lf_rc <= lf_q == 4'h0;
    lf_ext <= lf_q == 4'h5;
    lf_xtal <= lf_q[2:0] == 3'h3;
end
endmodule : hcs_osc_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench of the high-speed clock select block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hcs_pkg::*;
();
logic CLK = 1'b0;
logic RST = 1'b1;
logic SLEEP = 1'b0;
logic RC_TICK, XTAL_TICK, XTAL_GOOD, LF_RC_TICK, LF_EXT_TICK, LF_XTAL_TICK;
logic RC_EN, XTAL_EN, RADIO_CLK_EN, PERIPH_CLK_EN, CPU_CLK_EN, WAKE_TMR_EN, ON_XTAL;
logic [7:0] RC_TRIM;
logic [7:0] good_wait = 8'h14;
logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hf;
logic [31:0] WDATA = 32'h0, RDATA;
logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
logic [1:0] BRESP, RRESP;
logic [31:0] rs = 32'h4f;
int n_fail = 0, n_compared = 0;
always #4 CLK = ~CLK;
hcs_clk_sel dut (.*);
hcs_osc_model osc (.clk(CLK), .rc_en(RC_EN), .xtal_en(XTAL_EN), .good_wait(good_wait), .rc_tick(RC_TICK),
    .xtal_tick(XTAL_TICK), .xtal_good(XTAL_GOOD), .lf_rc(LF_RC_TICK), .lf_ext(LF_EXT_TICK), .lf_xtal(LF_XTAL_TICK));
////////////////////////////////////////
function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
endfunction : rnd
task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
        n_fail++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : check
task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask : final_report
// Waits end on the answer itself; the counter only guards against a hang
task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (t < 200) begin
        @(posedge CLK);
        t++;
        if (AWVALID && AWREADY) AWVALID <= 1'b0;
        if (WVALID && WREADY) WVALID <= 1'b0;
        if (BVALID === 1'b1) begin
            r = BRESP;
            t = 999;
        end
    end
    BREADY <= 1'b0;
    if (t != 999) n_fail++;
endtask : wr
task automatic rd(input logic [3:0] a, output logic [31:0] v);
    int t;
    t = 0;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (t < 200) begin
        @(posedge CLK);
        t++;
        if (ARVALID && ARREADY) ARVALID <= 1'b0;
        if (RVALID === 1'b1) begin
            v = RDATA;
            t = 999;
        end
    end
    RREADY <= 1'b0;
    if (t != 999) n_fail++;
endtask : rd
// Window of 64 radio pulses: a whole number of periods for every divider setting
task automatic rates(input int d, input bit chk);
    int nr, nc, np, t;
    nr = 0;
    nc = 0;
    np = 0;
    for (t = 0; t < 2000 && nr < 64; t++) begin
        @(posedge CLK);
        nr += int'(RADIO_CLK_EN === 1'b1);
        nc += int'(CPU_CLK_EN === 1'b1);
        np += int'(PERIPH_CLK_EN === 1'b1);
    end
    if (chk) check(32'(nc), 32'(64 >> d));
    if (chk) check(32'(np), 32'h20);
endtask : rates
task automatic wait_xtal();
    int t;
    for (t = 0; t < 400 && ON_XTAL !== 1'b1; t++) @(posedge CLK);
    check(32'(ON_XTAL), 32'h1);
endtask : wait_xtal
task automatic nap();
    @(posedge CLK);
    SLEEP <= 1'b1;
    good_wait <= 8'(rnd() % 32'h28);
    repeat (4) @(posedge CLK);
    SLEEP <= 1'b0;
    @(posedge CLK);
    check(32'(ON_XTAL), 32'h0);
endtask : nap
task automatic lf_follow(input bit ext);
    logic p;
    @(posedge CLK);
    p = ext ? LF_EXT_TICK : LF_RC_TICK;
    repeat (60) begin
        @(posedge CLK);
        check(32'(WAKE_TMR_EN), 32'(p));
        p = ext ? LF_EXT_TICK : LF_RC_TICK;
    end
endtask : lf_follow
////////////////////////////////////////
// Rates are checked on the crystal and, after the last sleep, on the RC source as well
initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] tr;
    int d, dv;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    check(32'(ON_XTAL), 32'h0);
    check(32'(RC_TRIM), 32'(HCS_TRIM_RST));
    rd(HCS_OFF_CTRL, v);
    check(v, 32'h0);
    lf_follow(1'b0);
    wr(HCS_OFF_LFSEL, 32'h1, r);
    wr(HCS_OFF_LFSEL, 32'h2, r);
    rd(HCS_OFF_LFSEL, v);
    check(v, 32'h1);
    lf_follow(1'b1);
    $display("low-speed source test done");
    wait_xtal();
    rd(HCS_OFF_STATUS, v);
    check(32'(v[1:0]), 32'h3);
    for (d = 0; d < 7; d++) begin
        dv = d < 6 ? d : int'(rnd() % 32'h6);
        wr(HCS_OFF_CTRL, 32'(dv) << HCS_CTRL_DIV_LSB, r);
        rates(dv, 1'b0);
        rates(dv, 1'b1);
        rd(HCS_OFF_STATUS, v);
        check(32'(v[HCS_ST_DIV_LSB +: 3]), 32'(dv));
    end
    $display("divider test done");
    tr = 8'(rnd());
    wr(HCS_OFF_RCCAL, {24'h0, tr}, r);
    check(32'(RC_TRIM), 32'(tr));
    nap();
    check(32'(RC_TRIM), 32'(tr));
    wait_xtal();
    wr(HCS_OFF_CTRL, 32'h1, r);
    nap();
    repeat (100) @(posedge CLK);
    check(32'(ON_XTAL), 32'h0);
    wr(HCS_OFF_CTRL, 32'h5, r);
    wait_xtal();
    wr(HCS_OFF_CTRL, 32'h52, r);
    nap();
    rates(5, 1'b0);
    rates(5, 1'b1);
    check(32'(ON_XTAL), 32'h0);
    check(32'(RC_TRIM), 32'(tr));
    $display("switch-over test done");
    wr(HCS_OFF_STATUS, 32'h0, r);
    check(32'(r), 32'(HCS_RESP_SLVERR));
    final_report();
end
initial begin
    repeat (40000) @(posedge CLK);
    n_fail++;
    final_report();
end
endmodule : tb_top
`default_nettype wire
